//--- spc_fcal.sv
`timescale 1ns/1ns
`default_nettype none

module spc_fcal
	import spc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic        ref_tick,
	input  wire logic [10:0] step_ticks,
	input  wire logic        vco_fast,
	output var  logic        busy,
	output var  logic        done,
	output var  logic [1:0]  core,
	output var  logic [7:0]  band
);

	// ***************************************************************
	// Successive approximation over {core, band}, timed by reference
	// ***************************************************************
	spc_fcal_state_t st_q, st_d;
	logic [SPC_CAL_W-1:0] trial_q, trial_d;
	logic [3:0]           idx_q, idx_d;
	logic [10:0]          cnt_q, cnt_d;
	logic                 done_q, done_d;
	logic [10:0]          reload;

	always_comb begin
		reload = (step_ticks == 11'h000) ? 11'h001 : step_ticks;
		st_d    = st_q;
		trial_d = trial_q;
		idx_d   = idx_q;
		cnt_d   = cnt_q;
		done_d  = 1'b0;
		case (st_q)
			SPC_FC_IDLE: begin
			end
			SPC_FC_WAIT: begin
				if (ref_tick) begin
					cnt_d = cnt_q - 11'h001;
					if (cnt_q == 11'h001) begin
						// Comparator says the VCO overshoots: drop trial bit
						if (vco_fast) begin
							trial_d[idx_q] = 1'b0;
						end
						if (idx_q == 4'h0) begin
							st_d   = SPC_FC_IDLE;
							done_d = 1'b1;
						end else begin
							idx_d = idx_q - 4'h1;
							trial_d[idx_q - 4'h1] = 1'b1;
							cnt_d = reload;
						end
					end
				end
			end
			default: st_d = SPC_FC_IDLE;
		endcase
		// A new start restarts the search from the top
		if (start) begin
			st_d    = SPC_FC_WAIT;
			trial_d = {1'b1, {(SPC_CAL_W-1){1'b0}}};
			idx_d   = 4'(SPC_CAL_W - 1);
			cnt_d   = reload;
			done_d  = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q    <= SPC_FC_IDLE;
			trial_q <= '0;
			idx_q   <= '0;
			cnt_q   <= '0;
			done_q  <= 1'b0;
		end else begin
			st_q    <= st_d;
			trial_q <= trial_d;
			idx_q   <= idx_d;
			cnt_q   <= cnt_d;
			done_q  <= done_d;
		end
	end

	assign busy = (st_q == SPC_FC_WAIT);
	assign done = done_q;
	assign core = trial_q[9:8];
	assign band = trial_q[7:0];

endmodule : spc_fcal

`default_nettype wire

//--- spc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module spc_host_model (
	input  wire logic pclk,
	input  wire logic lock_detect_out,
	output var  logic ser_clk,
	output var  logic ser_data,
	output var  logic word_latch_strobe,
	output var  logic reference_input
);
	logic [2:0] ref_cnt = 3'h0;
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		word_latch_strobe = 1'b0;
	end
	// Free running so calibration always has a timebase
	always @(posedge pclk) ref_cnt <= ref_cnt + 3'h1;
	assign reference_input = ref_cnt[2];

	// ***************************************************************
	// Serial link, every level held at least 3 pclk for the synchroniser
	// ***************************************************************
	task automatic tk(input int n);
		repeat (n) @(posedge pclk);
	endtask : tk
	task automatic pulse();
		ser_clk <= 1'b1;
		tk(3);
		ser_clk <= 1'b0;
		tk(3);
	endtask : pulse
	task automatic send_word(input logic [31:0] w);
		tk(1);
		for (int i = 31; i >= 0; i--) begin
			ser_data <= w[i];
			tk(3);
			pulse();
		end
		ser_data <= ~w[0];
		word_latch_strobe <= 1'b1;
		tk(4);
		word_latch_strobe <= 1'b0;
		tk(4);
	endtask : send_word
	task automatic read_word(output logic [31:0] r);
		tk(1);
		word_latch_strobe <= 1'b1;
		tk(8);
		for (int i = 31; i >= 0; i--) begin
			@(negedge pclk);
			r[i] = lock_detect_out;
			tk(1);
			pulse();
		end
		word_latch_strobe <= 1'b0;
		tk(4);
	endtask : read_word
endmodule : spc_host_model
`default_nettype wire

//--- spc_pkg.sv
package spc_pkg;

	// ***************************************************************
	// Word format on the serial link
	// ***************************************************************
	localparam int SPC_WORD_W       = 32;
	localparam int SPC_ADDR_W       = 4;
	localparam int SPC_ADDR_LSB     = 0;

	// Target register addresses carried in the low bits of a word
	localparam logic [3:0] SPC_TGT_MAIN = 4'h0;
	localparam logic [3:0] SPC_TGT_DEN  = 4'h1;
	localparam logic [3:0] SPC_TGT_CFG  = 4'h2;
	localparam logic [3:0] SPC_TGT_OUT  = 4'h3;
	localparam logic [3:0] SPC_TGT_RDBK = 4'h6;

	// ***************************************************************
	// Field layout
	// ***************************************************************
	localparam int SPC_ID_BIT       = 31;
	localparam int SPC_CALINH_BIT   = 30;
	localparam int SPC_NINT_LSB     = 16;
	localparam int SPC_NINT_W       = 12;
	localparam int SPC_NUMLO_LSB    = 4;
	localparam int SPC_NUMLO_W      = 12;
	localparam int SPC_DEN_LSB      = 4;
	localparam int SPC_DEN_W        = 22;
	localparam int SPC_NUMHI_LSB    = 4;
	localparam int SPC_NUMHI_W      = 10;
	localparam int SPC_ORDER_LSB    = 14;
	localparam int SPC_DITHER_LSB   = 16;
	localparam int SPC_DOUBLER_BIT  = 18;
	localparam int SPC_RDIV_LSB     = 20;
	localparam int SPC_RDIV_W       = 12;
	localparam int SPC_DIV_LSB      = 4;
	localparam int SPC_DIV_W        = 5;
	localparam int SPC_SRCA_BIT     = 9;
	localparam int SPC_SRCB_BIT     = 10;
	localparam int SPC_ZDLY_BIT     = 11;
	localparam int SPC_RATE_LSB     = 12;
	localparam int SPC_RATE_W       = 11;
	localparam int SPC_RDSEL_LSB    = 5;
	localparam int SPC_CAL_W        = 10;

	// ***************************************************************
	// Reset values and limits
	// ***************************************************************
	localparam logic [21:0] SPC_DEN_RST     = 22'h000001;
	localparam logic [4:0]  SPC_DIV_MAX     = 5'h12;
	localparam logic [10:0] SPC_RATE_RST    = 11'h001;
	localparam logic [11:0] SPC_RDIV_RST    = 12'h001;
	localparam logic [31:0] SPC_CTRL_RST    = 32'h00000001;

	// ***************************************************************
	// APB register map (byte addresses)
	// ***************************************************************
	localparam logic [7:0] SPC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] SPC_OFS_WORD   = 8'h04;
	localparam logic [7:0] SPC_OFS_CMD    = 8'h08;
	localparam logic [7:0] SPC_OFS_STATUS = 8'h0C;
	localparam logic [7:0] SPC_OFS_NINT   = 8'h10;
	localparam logic [7:0] SPC_OFS_NUM    = 8'h14;
	localparam logic [7:0] SPC_OFS_DEN    = 8'h18;
	localparam logic [7:0] SPC_OFS_OUTCFG = 8'h1C;

	typedef enum logic [0:0] {
		SPC_FC_IDLE,
		SPC_FC_WAIT
	} spc_fcal_state_t;

endpackage : spc_pkg

//--- spc_regmem.sv
`timescale 1ns/1ns
`default_nettype none

module spc_regmem
	import spc_pkg::*;
#(
	parameter int DW = 32,
	parameter int AW = 4
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output var  logic [DW-1:0] rdata
);

	// ***************************************************************
	// Storage of every latched word, kept for readback
	// ***************************************************************
	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] rdata_d;

	always_comb begin
		rdata_d = mem[raddr];
	end

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;

endmodule : spc_regmem

`default_nettype wire

//--- spc_top.sv
// Notes on behaviour
// - Serial data shifted in on clock rise
// - Strobe rise latches word into target
// - Strobe high: clocks shift readback word out
// - Doubler and reference divider usable together
// - Divider is integer plus numerator/denominator
// - Modulator order zero to three, dither selectable
// - Main word write resets the modulator
// - Calibration picks one core and band
// - Main word starts calibration unless inhibited
// - Even divide 2 to 38, per-output bypass
// - Zero-delay puts divider into feedback path
`timescale 1ns/1ns
`default_nettype none

module spc_top
	import spc_pkg::*;
#(
	parameter logic [31:0] ID_CODE = 32'h00005A00 // Arbitrary value
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        ser_clk,
	input  wire logic        ser_data,
	input  wire logic        word_latch_strobe,
	input  wire logic        reference_input,
	input  wire logic        vco_fast,
	output var  logic        lock_detect_out,
	output var  logic [11:0] feedback_integer_value,
	output var  logic [21:0] fraction_numerator,
	output var  logic [21:0] fraction_denominator,
	output var  logic [1:0]  modulator_order,
	output var  logic [1:0]  dither_mode,
	output var  logic        reference_doubler,
	output var  logic [11:0] reference_divider,
	output var  logic [5:0]  output_divider_ratio,
	output var  logic        output_a_bypass,
	output var  logic        output_b_bypass,
	output var  logic        zero_delay_enable,
	output var  logic [5:0]  feedback_path_ratio,
	output var  logic        modulator_reset,
	output var  logic        cal_busy,
	output var  logic        cal_done,
	output var  logic [1:0]  vco_core,
	output var  logic [7:0]  vco_band
);

	// ***************************************************************
	// Pin synchronisers and edge detection
	// ***************************************************************
	// Bits: 0 clock, 1 data, 2 strobe, 3 reference, 4 comparator
	logic [4:0] sync1_q, sync2_q, prev_q;
	logic       sclk_rise, strobe_rise, ref_rise;
	logic       sdata, strobe_lvl, fast_lvl;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q  <= '0;
		end else begin
			sync1_q <= {vco_fast, reference_input, word_latch_strobe,
				ser_data, ser_clk};
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	assign sclk_rise   = sync2_q[0] & ~prev_q[0];
	assign sdata       = sync2_q[1];
	assign strobe_lvl  = sync2_q[2];
	assign strobe_rise = sync2_q[2] & ~prev_q[2];
	assign ref_rise    = sync2_q[3] & ~prev_q[3];
	assign fast_lvl    = sync2_q[4];

	// ***************************************************************
	// Serial shift register and readback shifter
	// ***************************************************************
	logic [31:0] shift_q, shift_d;
	logic [31:0] rb_q, rb_d;
	logic [1:0]  rb_pend_q, rb_pend_d;
	logic        rbo_q, rbo_d;
	logic        id_q, id_d;
	logic [31:0] mem_rdata;

	always_comb begin
		shift_d   = shift_q;
		rb_d      = rb_q;
		rb_pend_d = {rb_pend_q[0], strobe_rise};
		if (sclk_rise) begin
			// MSB first, so address lands in the low bits
			shift_d = {shift_q[30:0], sdata};
			if (strobe_lvl) begin
				rb_d = {rb_q[30:0], 1'b0};
			end
		end
		// Load two cycles after the strobe so a fresh selection is seen
		if (rb_pend_q[1]) begin
			rb_d = id_q ? ID_CODE : mem_rdata;
		end
		rbo_d = strobe_lvl & rb_q[31];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q   <= '0;
			rb_q      <= '0;
			rb_pend_q <= '0;
			rbo_q     <= 1'b0;
		end else begin
			shift_q   <= shift_d;
			rb_q      <= rb_d;
			rb_pend_q <= rb_pend_d;
			rbo_q     <= rbo_d;
		end
	end

	assign lock_detect_out = rbo_q;

	// ***************************************************************
	// Latch event: serial strobe or APB command
	// ***************************************************************
	logic        ser_en_q, ser_en_d;
	logic [31:0] apb_word_q, apb_word_d;
	logic        apb_cmd;
	logic        latch_evt;
	logic [31:0] word;
	logic [3:0]  tgt;

	assign latch_evt = (strobe_rise & ser_en_q) | apb_cmd;
	assign word      = apb_cmd ? apb_word_q : shift_q;
	assign tgt       = word[SPC_ADDR_LSB +: SPC_ADDR_W];

	// ***************************************************************
	// Decoded control fields
	// ***************************************************************
	logic        calinh_q, calinh_d;
	logic [11:0] nint_q, nint_d;
	logic [11:0] numlo_q, numlo_d;
	logic [9:0]  numhi_q, numhi_d;
	logic [21:0] den_q, den_d;
	logic [1:0]  order_q, order_d;
	logic [1:0]  dither_q, dither_d;
	logic        dbl_q, dbl_d;
	logic [11:0] rdiv_q, rdiv_d;
	logic [4:0]  divc_q, divc_d;
	logic        srca_q, srca_d;
	logic        srcb_q, srcb_d;
	logic        zdly_q, zdly_d;
	logic [10:0] rate_q, rate_d;
	logic [3:0]  rdsel_q, rdsel_d;
	logic        modrst_q, modrst_d;
	logic        calgo_q, calgo_d;
	logic [4:0]  divc_new;
	logic [21:0] den_new;

	always_comb begin
		id_d     = id_q;
		calinh_d = calinh_q;
		nint_d   = nint_q;
		numlo_d  = numlo_q;
		numhi_d  = numhi_q;
		den_d    = den_q;
		order_d  = order_q;
		dither_d = dither_q;
		dbl_d    = dbl_q;
		rdiv_d   = rdiv_q;
		divc_d   = divc_q;
		srca_d   = srca_q;
		srcb_d   = srcb_q;
		zdly_d   = zdly_q;
		rate_d   = rate_q;
		rdsel_d  = rdsel_q;
		modrst_d = 1'b0;
		calgo_d  = 1'b0;
		divc_new = word[SPC_DIV_LSB +: SPC_DIV_W];
		den_new  = word[SPC_DEN_LSB +: SPC_DEN_W];
		if (latch_evt) begin
			if (tgt == SPC_TGT_MAIN) begin
				id_d     = word[SPC_ID_BIT];
				calinh_d = word[SPC_CALINH_BIT];
				nint_d   = word[SPC_NINT_LSB +: SPC_NINT_W];
				numlo_d  = word[SPC_NUMLO_LSB +: SPC_NUMLO_W];
				modrst_d = 1'b1;
				calgo_d  = ~word[SPC_CALINH_BIT];
			end else if (tgt == SPC_TGT_DEN) begin
				// Zero would be a divide by zero; held to one
				den_d = (den_new == '0) ? SPC_DEN_RST : den_new;
			end else if (tgt == SPC_TGT_CFG) begin
				numhi_d  = word[SPC_NUMHI_LSB +: SPC_NUMHI_W];
				order_d  = word[SPC_ORDER_LSB +: 2];
				dither_d = word[SPC_DITHER_LSB +: 2];
				dbl_d    = word[SPC_DOUBLER_BIT];
				rdiv_d   = word[SPC_RDIV_LSB +: SPC_RDIV_W];
			end else if (tgt == SPC_TGT_OUT) begin
				// Codes past 18 saturate at ratio 38 rather than wrap
				divc_d = (divc_new > SPC_DIV_MAX) ? SPC_DIV_MAX
					: divc_new;
				srca_d = word[SPC_SRCA_BIT];
				srcb_d = word[SPC_SRCB_BIT];
				zdly_d = word[SPC_ZDLY_BIT];
				rate_d = word[SPC_RATE_LSB +: SPC_RATE_W];
			end else if (tgt == SPC_TGT_RDBK) begin
				rdsel_d = word[SPC_RDSEL_LSB +: SPC_ADDR_W];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_q     <= 1'b0;
			id_q     <= 1'b0;
			calinh_q <= 1'b0;
			nint_q   <= '0;
			numlo_q  <= '0;
			numhi_q  <= '0;
			den_q    <= SPC_DEN_RST;
			order_q  <= '0;
			dither_q <= '0;
			dbl_q    <= 1'b0;
			rdiv_q   <= SPC_RDIV_RST;
			divc_q   <= '0;
			srca_q   <= 1'b0;
			srcb_q   <= 1'b0;
			zdly_q   <= 1'b0;
			rate_q   <= SPC_RATE_RST;
			rdsel_q  <= '0;
			modrst_q <= 1'b0;
			calgo_q  <= 1'b0;
		end else begin
			id_q     <= id_d;
			id_q     <= id_d;
			calinh_q <= calinh_d;
			nint_q   <= nint_d;
			numlo_q  <= numlo_d;
			numhi_q  <= numhi_d;
			den_q    <= den_d;
			order_q  <= order_d;
			dither_q <= dither_d;
			dbl_q    <= dbl_d;
			rdiv_q   <= rdiv_d;
			divc_q   <= divc_d;
			srca_q   <= srca_d;
			srcb_q   <= srcb_d;
			zdly_q   <= zdly_d;
			rate_q   <= rate_d;
			rdsel_q  <= rdsel_d;
			modrst_q <= modrst_d;
			calgo_q  <= calgo_d;
		end
	end

	assign feedback_integer_value = nint_q;
	assign fraction_numerator     = {numhi_q, numlo_q};
	assign fraction_denominator   = den_q;
	assign modulator_order        = order_q;
	assign dither_mode            = dither_q;
	assign reference_doubler      = dbl_q;
	assign reference_divider      = rdiv_q;
	assign output_divider_ratio   = {divc_q, 1'b0} + 6'h02;
	assign output_a_bypass        = ~srca_q;
	assign output_b_bypass        = ~srcb_q;
	assign zero_delay_enable      = zdly_q;
	assign feedback_path_ratio    = zdly_q ? output_divider_ratio
		: 6'h01;
	assign modulator_reset        = modrst_q;

	// ***************************************************************
	// Word store and calibration engine
	// ***************************************************************
	spc_regmem #(
		.DW (SPC_WORD_W),
		.AW (SPC_ADDR_W)
	) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (latch_evt),
		.waddr   (tgt),
		.wdata   (word),
		.raddr   (rdsel_q),
		.rdata   (mem_rdata)
	);

	// Search steps are timed from the synchronised reference
	spc_fcal u_fcal (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (calgo_q),
		.ref_tick   (ref_rise),
		.step_ticks (rate_q),
		.vco_fast   (fast_lvl),
		.busy       (cal_busy),
		.done       (cal_done),
		.core       (vco_core),
		.band       (vco_band)
	);

	// ***************************************************************
	// APB slave, zero wait states
	// ***************************************************************
	logic        wr_acc, rd_acc;
	logic        hit;
	logic [31:0] rd_val;

	assign wr_acc  = psel & penable & pwrite;
	assign rd_acc  = psel & penable & ~pwrite;
	assign apb_cmd = wr_acc & (paddr == SPC_OFS_CMD);
	assign pready  = 1'b1;

	always_comb begin
		hit    = 1'b1;
		rd_val = '0;
		if (paddr == SPC_OFS_CTRL) begin
			rd_val = {31'h0, ser_en_q};
		end else if (paddr == SPC_OFS_WORD) begin
			rd_val = apb_word_q;
		end else if (paddr == SPC_OFS_CMD) begin
			rd_val = '0;
		end else if (paddr == SPC_OFS_STATUS) begin
			rd_val = {20'h0, calinh_q, vco_band, vco_core, cal_busy};
		end else if (paddr == SPC_OFS_NINT) begin
			rd_val = {20'h0, nint_q};
		end else if (paddr == SPC_OFS_NUM) begin
			rd_val = {10'h0, numhi_q, numlo_q};
		end else if (paddr == SPC_OFS_DEN) begin
			rd_val = {10'h0, den_q};
		end else if (paddr == SPC_OFS_OUTCFG) begin
			rd_val = {23'h0, zdly_q, srcb_q, srca_q, 1'b0, divc_q};
		end else begin
			hit = 1'b0;
		end
		ser_en_d   = ser_en_q;
		apb_word_d = apb_word_q;
		if (wr_acc && paddr == SPC_OFS_CTRL) begin
			ser_en_d = pwdata[0];
		end
		if (wr_acc && paddr == SPC_OFS_WORD) begin
			apb_word_d = pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_en_q   <= SPC_CTRL_RST[0];
			apb_word_q <= '0;
		end else begin
			ser_en_q   <= ser_en_d;
			apb_word_q <= apb_word_d;
		end
	end

	assign prdata  = rd_acc ? rd_val : '0;
	assign pslverr = psel & penable & ~hit;

endmodule : spc_top

`default_nettype wire

//--- spc_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module spc_top_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        word_latch_strobe,
	input wire logic        lock_detect_out,
	input wire logic [11:0] feedback_integer_value,
	input wire logic [5:0]  output_divider_ratio,
	input wire logic        zero_delay_enable,
	input wire logic [5:0]  feedback_path_ratio,
	input wire logic        modulator_reset,
	input wire logic        cal_busy,
	input wire logic        cal_done
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ***************************************************************
	// Port relations
	// ***************************************************************
	property p_modrst_pulse;
		modulator_reset |=> !modulator_reset;
	endproperty
	a_modrst_pulse: assert property (p_modrst_pulse)
		else $error("modulator reset wider than one cycle");
	property p_main_field_cause;
		$changed(feedback_integer_value) |-> modulator_reset;
	endproperty
	a_main_field_cause: assert property (p_main_field_cause)
		else $error("integer value changed without modulator reset");
	property p_cal_start;
		$rose(cal_busy) |-> $past(modulator_reset);
	endproperty
	a_cal_start: assert property (p_cal_start)
		else $error("calibration started without a main word write");
	property p_cal_bound;
		$rose(cal_busy) |-> ##[1:1000] !cal_busy;
	endproperty
	a_cal_bound: assert property (p_cal_bound)
		else $error("calibration did not finish in time");
	property p_done_pulse;
		cal_done |=> !cal_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("calibration done wider than one cycle");
	property p_div_even;
		!output_divider_ratio[0] && output_divider_ratio inside {[6'h02:6'h26]};
	endproperty
	a_div_even: assert property (p_div_even)
		else $error("output divider ratio out of range");
	property p_fb_ratio;
		feedback_path_ratio == (zero_delay_enable ? output_divider_ratio : 6'h01);
	endproperty
	a_fb_ratio: assert property (p_fb_ratio)
		else $error("feedback ratio does not follow zero delay mode");
	property p_ld_idle;
		!word_latch_strobe [*5] |-> !lock_detect_out;
	endproperty
	a_ld_idle: assert property (p_ld_idle)
		else $error("readback output active with strobe low");
endmodule : spc_top_assertions
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top
	import spc_pkg::*;
;
	localparam logic [31:0] TB_ID = 32'h00003C00; // Arbitrary value
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        ser_clk, ser_data, word_latch_strobe, reference_input;
	logic        vco_fast, lock_detect_out, reference_doubler;
	logic        output_a_bypass, output_b_bypass, zero_delay_enable;
	logic        modulator_reset, cal_busy, cal_done;
	logic [7:0]  paddr, vco_band;
	logic [31:0] pwdata, prdata, rd, w;
	logic [11:0] feedback_integer_value, reference_divider, n12;
	logic [21:0] fraction_numerator, fraction_denominator, d22;
	logic [1:0]  modulator_order, dither_mode, vco_core;
	logic [5:0]  output_divider_ratio, feedback_path_ratio;
	// Ratio 4 is reached only through ratio 6
	logic [4:0]  codes [7] = '{5'h00, 5'h02, 5'h01, 5'h05, 5'h11,
		5'h12, 5'h1F};
	integer      seed;
	int          errors, n_tests, mr_cnt, m, i, k;

	spc_top #(.ID_CODE(TB_ID)) i_spc_top (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ser_clk,
		.ser_data, .word_latch_strobe, .reference_input, .vco_fast,
		.lock_detect_out, .feedback_integer_value, .fraction_numerator,
		.fraction_denominator, .modulator_order, .dither_mode,
		.reference_doubler, .reference_divider, .output_divider_ratio,
		.output_a_bypass, .output_b_bypass, .zero_delay_enable,
		.feedback_path_ratio, .modulator_reset, .cal_busy, .cal_done,
		.vco_core, .vco_band);
	spc_host_model i_spc_host_model (.pclk, .lock_detect_out, .ser_clk,
		.ser_data, .word_latch_strobe, .reference_input);

	always #20 pclk = ~pclk;
	always @(posedge pclk) if (modulator_reset === 1'b1) mr_cnt <= mr_cnt + 1;

	// ***************************************************************
	// Helpers
	// ***************************************************************
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		int j;
		@(posedge pclk);
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		for (j = 0; j < 20; j++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (j == 20) begin
			errors++;
			finish_test();
		end
	endtask : apb
	// Codes above 18 saturate at the largest ratio
	function automatic logic [31:0] f_ratio(input logic [4:0] c);
		return (c > 5'h12) ? 32'h26 : {26'h0, c, 1'b0} + 32'h2;
	endfunction : f_ratio

	initial begin
		seed = 32'h296E;
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, vco_fast} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check("den", 32'h1, 32'(fraction_denominator));
		check("ratio", 32'h2, 32'(output_divider_ratio));
		check("bypass", 32'h3, {output_a_bypass, output_b_bypass});
		apb(SPC_OFS_CTRL, 1'b0, 32'h0);
		check("ctrl", 32'h1, rd);
		apb(8'h40, 1'b0, 32'h0);
		check("unmapped", 32'h1, 32'(er));
		$display("test reset and bus done");
		for (k = 0; k < 3; k++) begin
			d22 = (k == 0) ? 22'h3FFFFF : 22'($random(seed)) | 22'h000001;
			w = {6'h00, d22, SPC_TGT_DEN};
			m = mr_cnt;
			i_spc_host_model.send_word(w);
			check("den", 32'(d22), 32'(fraction_denominator));
			check("modrst", m, mr_cnt);
		end
		i_spc_host_model.send_word({23'h0, 4'h1, 1'b0, SPC_TGT_RDBK});
		i_spc_host_model.read_word(rd);
		check("readback", w, rd);
		n12 = 12'($random(seed));
		m = mr_cnt;
		i_spc_host_model.send_word({2'b11, 2'b00, n12, 12'hABC, SPC_TGT_MAIN});
		check("nint", 32'(n12), 32'(feedback_integer_value));
		check("modrst", m + 1, mr_cnt);
		check("inhibit", 32'h0, 32'(cal_busy));
		i_spc_host_model.read_word(rd);
		check("ident", TB_ID, rd);
		$display("test serial words done");
		for (k = 0; k < 4; k++) begin
			n12 = 12'($random(seed)) | 12'h001;
			w = {n12, 2'b01, 2'(3 - k), 2'(k), 10'h155, SPC_TGT_CFG};
			i_spc_host_model.send_word(w);
			check("order", k, 32'(modulator_order));
			check("dither", 3 - k, 32'(dither_mode));
			check("refpath", {1'b1, n12}, {reference_doubler, reference_divider});
			check("num", 32'h155ABC, 32'(fraction_numerator));
		end
		for (k = 0; k < 7; k++) begin
			w = {20'h00001, k[0], k[1], ~k[0], codes[k], SPC_TGT_OUT};
			i_spc_host_model.send_word(w);
			check("ratio", f_ratio(codes[k]), 32'(output_divider_ratio));
			check("bypass", {k[0], ~k[1]}, {output_a_bypass, output_b_bypass});
			check("zdly", k[0] ? f_ratio(codes[k]) : 32'h1, 32'(feedback_path_ratio));
			check("zdly_en", 32'(k[0]), 32'(zero_delay_enable));
		end
		apb(SPC_OFS_OUTCFG, 1'b0, 32'h0);
		check("outcfg", 32'hD2, rd);
		$display("test fields done");
		apb(SPC_OFS_CTRL, 1'b1, 32'h0);
		i_spc_host_model.send_word({6'h00, 22'h000005, SPC_TGT_DEN});
		check("den_off", 32'(d22), 32'(fraction_denominator));
		apb(SPC_OFS_CTRL, 1'b1, 32'h1);
		apb(SPC_OFS_WORD, 1'b1, {6'h00, 22'h00002A, SPC_TGT_DEN});
		apb(SPC_OFS_CMD, 1'b1, 32'h0);
		apb(SPC_OFS_WORD, 1'b0, 32'h0);
		check("word", {6'h00, 22'h00002A, SPC_TGT_DEN}, rd);
		check("den_cmd", 32'h2A, 32'(fraction_denominator));
		$display("test register path done");
		for (k = 0; k < 2; k++) begin
			vco_fast <= k[0];
			// Zero-delay mode: inhibited write of N times ratio first
			w = {20'h00001, 3'b111, 5'h00, SPC_TGT_OUT};
			i_spc_host_model.send_word(w);
			w = {4'h4, 12'h0A0, 12'h000, SPC_TGT_MAIN};
			i_spc_host_model.send_word(w);
			check("inhibit", 32'h0, 32'(cal_busy));
			i_spc_host_model.send_word({4'h0, 12'h050, 12'h000, SPC_TGT_MAIN});
			for (i = 0; i < 2000 && cal_done !== 1'b1; i++) @(negedge pclk);
			if (i == 2000) begin
				errors++;
				finish_test();
			end
			@(negedge pclk);
			check("search", k[0] ? 32'h0 : 32'h3FF, {vco_core, vco_band});
			apb(SPC_OFS_STATUS, 1'b0, 32'h0);
			check("status", k[0] ? 32'h0 : 32'h7FE, rd);
		end
		$display("test calibration done");
		finish_test();
	end
endmodule : tb_top

bind spc_top spc_top_assertions i_spc_top_assertions (.pclk, .presetn,
	.word_latch_strobe, .lock_detect_out, .feedback_integer_value,
	.output_divider_ratio, .zero_delay_enable, .feedback_path_ratio,
	.modulator_reset, .cal_busy, .cal_done);
`default_nettype wire
